// File: verilog/posb_pkg.sv
/*
 * Package for the PWM output stage: register map, field positions,
 * reset values, mode and source encodings, and the state record.
 * Assumes a 32-bit Avalon-MM slave port with byte addresses.
 */
package posb_pkg;

    localparam int unsigned ADDR_W = 6;

    // Register byte offsets
    localparam logic [5:0] OFS_CTRL   = 6'h00;
    localparam logic [5:0] OFS_DBAND  = 6'h04;
    localparam logic [5:0] OFS_STEER0 = 6'h08;
    localparam logic [5:0] OFS_STEER1 = 6'h0c;
    localparam logic [5:0] OFS_BURST  = 6'h10;
    localparam logic [5:0] OFS_SDCTRL = 6'h14;
    localparam logic [5:0] OFS_SDSRC  = 6'h18;
    localparam logic [5:0] OFS_SDLVL  = 6'h1c;
    localparam logic [5:0] OFS_STATUS = 6'h20;

    // Control register fields
    localparam int unsigned CTRL_EN   = 0;
    localparam int unsigned CTRL_LD   = 1;
    localparam int unsigned CTRL_MODE = 2;
    localparam int unsigned CTRL_DBRE = 4;
    localparam int unsigned CTRL_DBFE = 5;

    // Dead-band register fields
    localparam int unsigned DB_RISE = 0;
    localparam int unsigned DB_FALL = 8;

    // Burst register fields
    localparam int unsigned BU_EN   = 0;
    localparam int unsigned BU_SOFT = 1;
    localparam int unsigned BU_SEL  = 4;

    // Shutdown control fields
    localparam int unsigned SD_EN    = 0;
    localparam int unsigned SD_ACT   = 1;
    localparam int unsigned SD_OVR   = 2;
    localparam int unsigned SD_ARS   = 3;
    localparam int unsigned SD_EVENT = 4;

    // Number of outside trigger lines: gate pin, 2 capture/compare, 4 comparators
    localparam int unsigned NSRC = 7;

    // Burst source selection codes
    localparam logic [2:0] MSRC_SOFT = 3'h7;

    // Reset values
    localparam logic [5:0] RST_STEER = 6'h00;
    localparam logic [5:0] RST_LVL   = 6'h00;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'b00,
        MODE_COMPL  = 2'b01,
        MODE_3PH    = 2'b10,
        MODE_FIXED  = 2'b11
    } posb_mode_e;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_ON   = 2'b01,
        RUN_STOP = 2'b10
    } posb_run_e;

    typedef struct packed {
        logic             wait_n;
        logic [31:0]      rdata;
        logic             en;
        logic             ld;
        posb_mode_e       mode;
        logic             dbre;
        logic             dbfe;
        logic [7:0]       dbr;
        logic [7:0]       dbf;
        logic [5:0]       steer_sel;
        logic [5:0]       steer_buf;
        logic [5:0]       steer_act;
        logic             ssync;
        logic             bu_en;
        logic             bu_soft;
        logic [2:0]       bu_sel;
        logic             sd_en;
        logic             sd_act;
        logic             sd_ovr;
        logic             sd_ars;
        logic [NSRC-1:0]  sd_src;
        logic [5:0]       sd_lvl;
        logic             sd_hold;
        logic             cond_q;
        logic [NSRC-1:0]  meta;
        logic [NSRC-1:0]  sync;
        logic             pwm;
        logic [7:0]       cnt_r;
        logic [7:0]       cnt_f;
        logic             freeze;
        posb_run_e        run;
        logic             restart;
        logic             frz_out;
        logic             irq;
        logic [5:0]       out;
    } posb_state_s;

endpackage

// File: verilog/posb_top.sv
/*
 * PWM output stage: dead-band overlap handling, output steering,
 * burst gating and auto-shutdown overrides, behind an Avalon-MM slave.
 * Assumes the PWM core supplies period, rising and falling edge events
 * as one-cycle pulses on i_clock; gate, capture/compare and comparator
 * lines are asynchronous.
 */
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/100ps

module posb_top
    import posb_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic              i_rstn,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic              i_period_evt,
    input  wire logic              i_rise_evt,
    input  wire logic              i_fall_evt,
    input  wire logic              i_gate_pin,
    input  wire logic [1:0]        i_ccp_out,
    input  wire logic [3:0]        i_cmp_out,
    output logic [5:0]             o_out,
    output logic                   o_core_restart,
    output logic                   o_core_freeze,
    output logic                   o_shutdown_irq
);

    logic        rst_meta;
    logic        rst_n;
    posb_state_s st;
    posb_state_s next_st;

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Combinational helpers
    logic        req;
    logic        wr;
    logic [31:0] wd;
    logic [31:0] rd;
    logic        mod_lvl;
    logic        cond;
    logic        sd_now;
    logic        pri;
    logic        cpl;
    logic [5:0]  steer;
    logic [5:0]  drive;
    logic [5:0]  lowbit;
    logic [31:0] ctrl_rd;
    logic [31:0] sd_rd;

    assign req = (i_avs_read | i_avs_write) & rst_n;
    assign wr  = i_avs_write & ~st.wait_n;

    // Byte-lane merge of write data over the addressed register's current value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        ctrl_rd = 32'h0;
        ctrl_rd[CTRL_EN] = st.en;
        ctrl_rd[CTRL_LD] = st.ld;
        ctrl_rd[CTRL_MODE +: 2] = st.mode;
        ctrl_rd[CTRL_DBRE] = st.dbre;
        ctrl_rd[CTRL_DBFE] = st.dbfe;
        sd_rd = 32'h0;
        sd_rd[SD_EN]    = st.sd_en;
        sd_rd[SD_ACT]   = st.sd_act;
        sd_rd[SD_OVR]   = st.sd_ovr;
        sd_rd[SD_ARS]   = st.sd_ars;
        sd_rd[SD_EVENT] = st.sd_hold;
    end

    always_comb begin
        case (i_avs_address)
            OFS_CTRL:   rd = ctrl_rd;
            OFS_DBAND:  rd = {16'h0, st.dbf, st.dbr};
            OFS_STEER0: rd = {26'h0, st.steer_sel};
            OFS_STEER1: rd = {31'h0, st.ssync};
            OFS_BURST:  rd = {25'h0, st.bu_sel, 2'h0, st.bu_soft, st.bu_en};
            OFS_SDCTRL: rd = sd_rd;
            OFS_SDSRC:  rd = {25'h0, st.sd_src};
            OFS_SDLVL:  rd = {26'h0, st.sd_lvl};
            OFS_STATUS: rd = {22'h0, st.run, st.freeze, st.sd_hold, st.out};
            default:    rd = 32'h0;
        endcase
        wd = merge(rd, i_avs_writedata, i_avs_byteenable);
    end

    // Burst source: one of seven lines, or the software bit at code 7, chosen by a 3-bit code
    always_comb begin
        if (st.bu_sel == MSRC_SOFT) begin
            mod_lvl = st.bu_soft;
        end else begin
            mod_lvl = st.sync[st.bu_sel];
        end
    end

    assign cond   = st.sd_en & |(st.sync & st.sd_src);
    assign sd_now = st.sd_en & (st.sd_act | st.sd_ovr | cond);
    assign pri    = st.pwm & (st.cnt_r == 8'h0);
    assign cpl    = ~st.pwm & (st.cnt_f == 8'h0);
    assign steer  = st.ssync ? st.steer_act : st.steer_sel;
    assign lowbit = steer & (~steer + 6'h1);

    // Steering patterns per mode
    always_comb begin
        drive = 6'h0;
        case (st.mode)
            MODE_SINGLE: begin
                drive = {6{pri}} & steer;
            end
            MODE_COMPL: begin
                drive[0] = pri & steer[0];
                drive[2] = pri & steer[2];
                drive[1] = cpl & steer[1];
                drive[3] = cpl & steer[3];
                drive[4] = (pri & steer[4]) | (cpl & steer[5]);
            end
            MODE_3PH: begin
                case (lowbit)
                    6'h01:   drive = {1'b0, 1'b0, pri, 1'b0, 1'b0, pri};
                    6'h02:   drive = {pri, 1'b0, 1'b0, 1'b0, 1'b0, pri};
                    6'h04:   drive = {pri, 1'b0, 1'b0, pri, 1'b0, 1'b0};
                    6'h08:   drive = {1'b0, 1'b0, 1'b0, pri, pri, 1'b0};
                    6'h10:   drive = {1'b0, pri, 1'b0, 1'b0, pri, 1'b0};
                    6'h20:   drive = {1'b0, pri, pri, 1'b0, 1'b0, 1'b0};
                    default: drive = 6'h0;
                endcase
            end
            default: begin
                drive[0] = pri;
                drive[1] = cpl;
            end
        endcase
    end

    always_comb begin
        next_st = st;
        next_st.restart = 1'b0;
        next_st.irq     = 1'b0;
        next_st.meta    = {i_cmp_out, i_ccp_out, i_gate_pin};
        next_st.sync    = st.meta;
        next_st.cond_q  = cond;

        // Bus slave: one wait cycle, answer on the next edge
        next_st.wait_n = 1'b1;
        if (req && st.wait_n) begin
            next_st.wait_n = 1'b0;
            next_st.rdata  = rd;
        end

        // Load request is consumed at the period event
        if (i_period_evt && st.ld) begin
            next_st.steer_act = st.steer_buf;
            next_st.ld        = 1'b0;
        end

        if (wr) begin
            case (i_avs_address)
                OFS_CTRL: begin
                    next_st.en   = wd[CTRL_EN];
                    next_st.mode = posb_mode_e'(wd[CTRL_MODE +: 2]);
                    next_st.dbre = wd[CTRL_DBRE];
                    next_st.dbfe = wd[CTRL_DBFE];
                    if (wd[CTRL_LD]) begin
                        next_st.ld = 1'b1;
                    end
                    if ((wd[CTRL_EN] && !st.en) || wd[CTRL_LD]) begin
                        next_st.steer_buf = st.steer_sel;
                    end
                end
                OFS_DBAND: begin
                    next_st.dbr = wd[DB_RISE +: 8];
                    next_st.dbf = wd[DB_FALL +: 8];
                end
                OFS_STEER0: next_st.steer_sel = wd[5:0];
                OFS_STEER1: begin
                    next_st.ssync = wd[0];
                    if (wd[0] && !st.ssync) begin
                        next_st.steer_act = st.steer_buf;
                    end
                end
                OFS_BURST: begin
                    next_st.bu_en   = wd[BU_EN];
                    next_st.bu_soft = wd[BU_SOFT];
                    next_st.bu_sel  = wd[BU_SEL +: 3];
                end
                OFS_SDCTRL: begin
                    next_st.sd_en  = wd[SD_EN];
                    next_st.sd_ovr = wd[SD_OVR];
                    next_st.sd_ars = wd[SD_ARS];
                    if (wd[SD_ACT]) begin
                        next_st.sd_act = 1'b1;
                        next_st.irq    = ~st.sd_act & wd[SD_EN];
                    end else if (!cond) begin
                        next_st.sd_act = 1'b0;
                    end
                end
                OFS_SDSRC: next_st.sd_src = wd[NSRC-1:0];
                OFS_SDLVL: next_st.sd_lvl = wd[5:0];
                default: begin
                end
            endcase
        end

        // Outside source: set wins over any clear in the same cycle except disabling shutdown
        if (cond) begin
            next_st.sd_act = 1'b1;
        end else if (st.sd_ars && st.cond_q) begin
            next_st.sd_act = 1'b0;
        end
        if (cond && !st.cond_q) begin
            next_st.irq = 1'b1;
        end
        if (!next_st.sd_en) begin
            next_st.sd_act = 1'b0;
            next_st.irq    = 1'b0;
        end

        // Override holds until a period event after the cause is gone, or until shutdown is disabled
        if (sd_now) begin
            next_st.sd_hold = 1'b1;
        end else if (i_period_evt || !st.sd_en) begin
            next_st.sd_hold = 1'b0;
        end

        // Burst gating
        case (st.run)
            RUN_IDLE: begin
                if (!st.bu_en || mod_lvl) begin
                    next_st.run     = RUN_ON;
                    next_st.restart = st.bu_en;
                end
            end
            RUN_ON: begin
                if (st.bu_en && !mod_lvl) begin
                    next_st.run = RUN_STOP;
                end
            end
            RUN_STOP: begin
                if (!st.bu_en || mod_lvl) begin
                    next_st.run = RUN_ON;
                end else if (i_period_evt && (st.mode != MODE_FIXED || st.pwm)) begin
                    next_st.run = RUN_IDLE;
                end
            end
            default: next_st.run = RUN_IDLE;
        endcase
        next_st.frz_out = (next_st.run == RUN_IDLE);

        // PWM level and dead-band counters
        if (st.run == RUN_IDLE || !st.en) begin
            next_st.pwm    = 1'b0;
            next_st.cnt_r  = 8'h0;
            next_st.cnt_f  = 8'h0;
            next_st.freeze = 1'b0;
        end else if (st.mode == MODE_FIXED) begin
            if (i_period_evt) begin
                next_st.pwm = ~st.pwm;
            end
        end else begin
            if (st.cnt_r != 8'h0) begin
                next_st.cnt_r = st.cnt_r - 8'h1;
            end
            if (st.cnt_f != 8'h0) begin
                next_st.cnt_f = st.cnt_f - 8'h1;
            end
            if (i_rise_evt) begin
                next_st.pwm   = 1'b1;
                next_st.cnt_f = 8'h0;
                if (st.dbre && st.mode != MODE_3PH) begin
                    next_st.cnt_r = st.dbr;
                    if (st.cnt_r > 8'h1) begin
                        next_st.freeze = 1'b1;
                    end
                end
            end else if (i_fall_evt) begin
                next_st.pwm   = 1'b0;
                next_st.cnt_r = 8'h0;
                if (st.dbfe && st.mode != MODE_3PH) begin
                    next_st.cnt_f = st.dbf;
                    if (st.cnt_f > 8'h1) begin
                        next_st.freeze = 1'b1;
                    end
                end
            end else if (st.freeze && next_st.cnt_r == 8'h0 && next_st.cnt_f == 8'h0) begin
                next_st.freeze = 1'b0;
            end
        end

        // Output priority: shutdown, then idle, then frozen, then steering
        // Levels appear in the same cycle as the flag and the interrupt
        if (sd_now || st.sd_hold || (next_st.sd_en && (next_st.sd_act || next_st.sd_ovr))) begin
            next_st.out = st.sd_lvl;
        end else if (st.run == RUN_IDLE || !st.en) begin
            next_st.out = 6'h0;
        end else if (st.freeze || next_st.freeze) begin
            next_st.out = st.out;
        end else begin
            next_st.out = drive;
        end
    end

    always_ff @(posedge i_clock or negedge rst_n) begin
        if (!rst_n) begin
            st           <= '0;
            st.wait_n    <= 1'b1;
            st.mode      <= MODE_SINGLE;
            st.run       <= RUN_IDLE;
            st.frz_out   <= 1'b1;
            st.steer_sel <= RST_STEER;
            st.sd_lvl    <= RST_LVL;
        end else begin
            st <= next_st;
        end
    end

    assign o_avs_readdata    = st.rdata;
    assign o_avs_waitrequest = st.wait_n;
    assign o_out             = st.out;
    assign o_core_restart    = st.restart;
    assign o_core_freeze     = st.frz_out;
    assign o_shutdown_irq    = st.irq;

endmodule

// File: dv/posb_core_model.sv
/* PWM core event model: period, rise and fall pulses.
 * Assumes the same clock as the output stage. */
`timescale 1ns/100ps
module posb_core_model #(
    parameter int PER = 16
) (
    input  wire logic i_clock,
    input  wire logic i_rstn,
    input  wire logic i_restart,
    output logic      o_period_evt,
    output logic      o_rise_evt,
    output logic      o_fall_evt
);
    logic [7:0] cnt;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt          <= 8'h00;
            o_period_evt <= 1'b0;
            o_rise_evt   <= 1'b0;
            o_fall_evt   <= 1'b0;
        end else begin
            // Restart begins a fresh period at once
            cnt          <= (i_restart || cnt == 8'(PER - 1)) ? 8'h00 : cnt + 8'h01;
            o_period_evt <= (cnt == 8'h00);
            o_rise_evt   <= (cnt == 8'h01);
            o_fall_evt   <= (cnt == 8'(PER / 2));
        end
    end
endmodule

// File: dv/posb_top_assertions.sv
/* Checker for the PWM output stage ports.
 * Assumes full-lane register writes and one clock domain. */
`timescale 1ns/100ps
module posb_top_assertions
    import posb_pkg::*;
(
    input wire logic              i_clock,
    input wire logic              i_rstn,
    input wire logic [ADDR_W-1:0] i_avs_address,
    input wire logic              i_avs_read,
    input wire logic              i_avs_write,
    input wire logic [31:0]       i_avs_writedata,
    input wire logic [3:0]        i_avs_byteenable,
    input wire logic [31:0]       o_avs_readdata,
    input wire logic              o_avs_waitrequest,
    input wire logic [5:0]        o_out,
    input wire logic              o_core_restart,
    input wire logic              o_shutdown_irq
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    logic [5:0] lvl_q;
    logic       sd_en_q;
    logic       bu_en_q;
    logic       acc;
    assign acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
    // Shadow copies of the fields the assertions depend on
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            lvl_q   <= RST_LVL;
            sd_en_q <= 1'b0;
            bu_en_q <= 1'b0;
        end else if (acc) begin
            if (i_avs_address == OFS_SDLVL) lvl_q <= i_avs_writedata[5:0];
            if (i_avs_address == OFS_SDCTRL) sd_en_q <= i_avs_writedata[SD_EN];
            if (i_avs_address == OFS_BURST) bu_en_q <= i_avs_writedata[BU_EN];
        end
    end
    sequence s_lvl_held;
        (o_out == lvl_q) [*2];
    endsequence
    a_sd_levels: assert property (o_shutdown_irq |-> s_lvl_held)
        else $error("shutdown levels not driven");
    a_irq_needs_en: assert property (o_shutdown_irq |-> sd_en_q)
        else $error("interrupt with shutdown disabled");
    a_irq_pulse: assert property (o_shutdown_irq |=> !o_shutdown_irq)
        else $error("interrupt longer than one cycle");
    a_restart_pulse: assert property (o_core_restart |=> !o_core_restart)
        else $error("restart longer than one cycle");
    a_restart_burst: assert property (o_core_restart |-> bu_en_q)
        else $error("restart without burst enabled");
    a_wait_one: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low too long");
    a_wait_idle: assert property (!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
        else $error("answer without request");
    a_rdata_stands: assert property (o_avs_waitrequest && $past(o_avs_waitrequest)
        |-> $stable(o_avs_readdata)) else $error("read data changed while idle");
endmodule
bind posb_top posb_top_assertions chk_u (.*);

// File: dv/posb_top_bench.sv
/* Self-checking bench for the PWM output stage.
 * Assumes the core event model and the port checker beside it. */
`timescale 1ns/100ps
module posb_top_bench;
    import posb_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_rstn  = 1'b0;
    logic [5:0]  addr    = 6'h00;
    logic        rd_s    = 1'b0;
    logic        wr_s    = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic [6:0]  src     = 7'h00;
    logic [31:0] rdata;
    logic [31:0] d;
    logic        wreq;
    logic        pe;
    logic        re;
    logic        fe;
    logic [5:0]  out;
    logic        restart;
    logic        freeze;
    logic        irq;
    int          failures = 0;
    int          checks   = 0;
    int          irqs     = 0;
    always #10 i_clock = ~i_clock;
    always @(posedge i_clock) if (irq === 1'b1) irqs++;
    posb_top dut_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_avs_address(addr),
        .i_avs_read(rd_s), .i_avs_write(wr_s), .i_avs_writedata(wdata),
        .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
        .i_period_evt(pe), .i_rise_evt(re), .i_fall_evt(fe), .i_gate_pin(src[0]),
        .i_ccp_out(src[2:1]), .i_cmp_out(src[6:3]), .o_out(out),
        .o_core_restart(restart), .o_core_freeze(freeze), .o_shutdown_irq(irq));
    posb_core_model core_u (.i_clock(i_clock), .i_rstn(i_rstn), .i_restart(restart),
        .o_period_evt(pe), .o_rise_evt(re), .o_fall_evt(fe));
    task end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task co(input logic [5:0] e);
        chk({26'h0, out}, {26'h0, e});
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [31:0] v);
        @(posedge i_clock);
        addr  <= a;
        wdata <= v;
        wr_s  <= w;
        rd_s  <= !w;
        do @(posedge i_clock); while (wreq !== 1'b0);
        d = rdata;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
    endtask
    // Wait for a core event (0 period, 1 rise, 2 fall), then let outputs settle
    task ev(input int k);
        do @(posedge i_clock); while ((k == 0 ? pe : k == 1 ? re : fe) !== 1'b1);
        repeat (3) @(posedge i_clock);
    endtask
    task t_steer();
        logic [5:0] st [3];
        logic [5:0] ex [3];
        st = '{6'h01, 6'h06, 6'h20};
        ex = '{6'h09, 6'h21, 6'h18};
        bus(1, 6'h3c, 32'hffffffff);
        bus(0, 6'h3c, 32'h0);
        chk(d, 32'h0);
        bus(1, OFS_STEER0, 32'h0);
        bus(1, OFS_CTRL, 32'h1);
        bus(1, OFS_STEER0, 32'h2d);
        ev(1);
        co(6'h2d);
        ev(2);
        co(6'h00);
        bus(1, OFS_CTRL, 32'h5);
        bus(1, OFS_STEER0, 32'h0f);
        ev(1);
        co(6'h05);
        ev(2);
        co(6'h0a);
        bus(1, OFS_CTRL, 32'h9);
        for (int i = 0; i < 3; i++) begin
            bus(1, OFS_STEER0, {26'h0, st[i]});
            ev(1);
            co(ex[i]);
        end
    endtask
    task t_sync();
        bus(1, OFS_CTRL, 32'h1);
        bus(1, OFS_STEER0, 32'h01);
        bus(1, OFS_CTRL, 32'h3);
        bus(1, OFS_STEER0, 32'h02);
        ev(1);
        co(6'h02);
        bus(1, OFS_STEER1, 32'h1);
        ev(1);
        co(6'h01);
        bus(1, OFS_STEER0, 32'h04);
        ev(1);
        co(6'h01);
        bus(1, OFS_CTRL, 32'h3);
        ev(0);
        ev(1);
        co(6'h04);
        bus(1, OFS_STEER1, 32'h0);
        bus(1, OFS_STEER0, 32'h01);
    endtask
    task t_burst();
        bus(1, OFS_BURST, 32'h70);
        ev(1);
        co(6'h01);
        bus(1, OFS_BURST, 32'h71);
        repeat (40) @(posedge i_clock);
        co(6'h00);
        chk({31'h0, freeze}, 32'h1);
        for (int k = 0; k < 8; k++) begin
            bus(1, OFS_BURST, 32'(k * 16 + 1));
            src <= 7'h00;
            repeat (40) @(posedge i_clock);
            chk({31'h0, freeze}, 32'h1);
            if (k < 7) begin
                src <= 7'(1 << k);
            end else begin
                bus(1, OFS_BURST, 32'h73);
            end
            do @(posedge i_clock); while (restart !== 1'b1);
            ev(1);
            co(6'h01);
        end
        bus(1, OFS_BURST, 32'h0);
        src <= 7'h00;
    endtask
    task t_shut();
        bus(1, OFS_SDLVL, 32'h2a);
        bus(1, OFS_SDSRC, 32'h01);
        src <= 7'h01;
        repeat (10) @(posedge i_clock);
        chk(32'(irqs), 32'h0);
        src <= 7'h00;
        bus(1, OFS_SDCTRL, 32'h1);
        src <= 7'h01;
        repeat (8) @(posedge i_clock);
        co(6'h2a);
        bus(1, OFS_SDCTRL, 32'h1);
        bus(0, OFS_SDCTRL, 32'h0);
        chk(d & 32'h12, 32'h12);
        co(6'h2a);
        src <= 7'h00;
        repeat (8) @(posedge i_clock);
        bus(1, OFS_SDCTRL, 32'h1);
        bus(0, OFS_SDCTRL, 32'h0);
        chk(d & 32'h2, 32'h0);
        ev(0);
        ev(1);
        co(6'h01);
        bus(1, OFS_SDCTRL, 32'h9);
        src <= 7'h01;
        repeat (8) @(posedge i_clock);
        src <= 7'h00;
        repeat (8) @(posedge i_clock);
        bus(0, OFS_SDCTRL, 32'h0);
        chk(d & 32'h2, 32'h0);
        bus(1, OFS_SDCTRL, 32'h5);
        repeat (3) @(posedge i_clock);
        co(6'h2a);
        chk(32'(irqs), 32'h2);
        bus(1, OFS_SDCTRL, 32'h3);
        repeat (3) @(posedge i_clock);
        co(6'h2a);
        bus(1, OFS_SDCTRL, 32'h0);
    endtask
    initial begin
        repeat (5) @(posedge i_clock);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clock);
        t_steer();
        t_sync();
        t_burst();
        t_shut();
        end_sim();
    end
    initial begin
        repeat (30000) @(posedge i_clock);
        failures++;
        end_sim();
    end
endmodule
